// *** hdl/acs_pkg.sv ***
// Shared constants, types and carriers of the converter control sequencer.
// Function
// - Strobe fall starts sampling the preset channel.
// - Strobe rise holds sample and ends sampling.
// - Strobe resamples and discards the pending result.
// - Conversion starts two system clocks after rise.
// - Strobe fall sets the read-out flag and its pending copy.
// - Chip-select fall tests flag: convert or read-out.
// - Normal cycle samples six serial clocks, converts.
// - Extended sampling only while chip select high.
// - Two read-out cycles clear the read-out state.
// - Code 9h fast, Ah slow, immediate, persistent.
// - Power-down leaves conversion rate unchanged.
// - Code 8h powers down; chip-select fall wakes.
// - Power-up: end-of-conversion high, command cleared.
// - Chip select high then low reinitialises cycle.
// - Flag cleared at chip-select rise ending cycle.
// - Clock invert low inverts command shift clock.
// - Inverted clock: output changes on sampling edge.
// - Frame sync at chip-select fall picks mode.
// - Four-bit command shifted in MSB first.
// - Codes select inputs or fixed test results.
// - Sampling edge follows mode and clock invert.
package acs_pkg;
	localparam int RES_W = 10;
	localparam int CMD_W = 4;
	typedef logic [RES_W-1:0] acs_word_t;
	typedef logic [CMD_W-1:0] acs_cmd_t;
	localparam acs_cmd_t CMD_PWRDN = 4'h8;
	localparam acs_cmd_t CMD_FAST = 4'h9;
	localparam acs_cmd_t CMD_SLOW = 4'hA;
	localparam acs_cmd_t CMD_TEST_MID = 4'hB;
	localparam acs_cmd_t CMD_TEST_LO = 4'hC;
	localparam acs_cmd_t CMD_TEST_HI = 4'hD;
	localparam acs_cmd_t CMD_LAST_CHAN = 4'h7;
	localparam acs_word_t RES_MID = 10'h200;
	localparam acs_word_t RES_LO = 10'h000;
	localparam acs_word_t RES_HI = 10'h3FF;
	localparam logic [3:0] EDGE_CMD_DONE = 4'h3;
	localparam logic [3:0] EDGE_CONVERT = 4'h9;
	localparam logic [3:0] EDGE_LAST = 4'hF;
	localparam acs_cmd_t CMD_RST = 4'h0;
	localparam logic EOC_RST = 1'b1;
	localparam logic FAST_RST = 1'b1;
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_FAST_NS = 7000;
	localparam int T_SLOW_NS = 15000;
	localparam logic [9:0] CONV_FAST_CYC = 10'(T_FAST_NS / CLK_PERIOD_NS);
	localparam logic [9:0] CONV_SLOW_CYC = 10'(T_SLOW_NS / CLK_PERIOD_NS);
	localparam logic [9:0] START_DELAY_CYC = 10'h002;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_NORM_SAMPLE = 5'h02,
		ST_EXT_SAMPLE = 5'h04,
		ST_EXT_WAIT = 5'h08,
		ST_CONVERT = 5'h10
	} acs_state_t;
	typedef struct packed {
		acs_cmd_t cmd;
		logic cmd_tgl;
		logic samp_tgl;
		logic conv_tgl;
	} acs_link_t;
	typedef struct packed {
		acs_state_t st;
		logic [9:0] cnt;
		logic cs_s1, cs_s2, cs_d;
		logic sb_s1, sb_s2, sb_d;
		logic [2:0] tg_s1, tg_s2, tg_d;
		logic flag, pend, conv_ok, fast, pwr_dn, eoc, sh;
		acs_cmd_t chan;
		acs_word_t out_word;
	} acs_seq_t;
	// Codes that start a sample and produce a result.
	function automatic logic acs_is_conv(input acs_cmd_t c);
		return (c <= CMD_LAST_CHAN) || (c >= CMD_TEST_MID && c <= CMD_TEST_HI);
	endfunction
endpackage

// *** hdl/acs_link.sv ***
// Serial link end: command shifter, bit counter and result shifter.
`timescale 1ns/1ps
module acs_link (
	input wire logic link_clk_i,
	input wire logic cs_n_i,
	input wire logic frame_sync_i,
	input wire logic data_in_i,
	input wire logic conv_ok_i,
	input acs_pkg::acs_word_t out_word_i,
	output acs_pkg::acs_link_t link_o,
	output logic edge_mode_o,
	output logic host_cpu_mode_o,
	output logic data_out_o
);
	import acs_pkg::*;
	// Event levels live here so that chip select high clears them; a toggle held
	// across cycles would start unknown, because this domain has no reset.
	typedef struct packed {
		logic [3:0] cnt;
		logic samp_on;
		logic cmd_lv, samp_lv, conv_lv;
	} cyc_t;
	typedef struct packed {
		acs_cmd_t cmd;
		acs_cmd_t sh;
		logic mode, ok_s1, ok_s2, dout;
	} hold_t;
	cyc_t c_reg, c_next;
	hold_t h_reg, h_next;
	acs_word_t shifted;
	acs_cmd_t cmd_now;
	// Until the first edge the mode is the live frame sync level.
	assign edge_mode_o = (c_reg.cnt == 4'h0) ? frame_sync_i : h_reg.mode;
	// Event fields are levels that rise at most once per cycle and fall at chip select high.
	assign link_o = '{cmd: h_reg.cmd, cmd_tgl: c_reg.cmd_lv, samp_tgl: c_reg.samp_lv,
		conv_tgl: c_reg.conv_lv};
	assign host_cpu_mode_o = h_reg.mode;
	assign data_out_o = h_reg.dout;
	// Edge counting and shifting on the selected sampling edge.
	always_comb begin
		c_next = c_reg;
		h_next = h_reg;
		shifted = out_word_i << c_reg.cnt;
		cmd_now = {h_reg.sh[CMD_W-2:0], data_in_i};
		h_next.ok_s1 = conv_ok_i;
		h_next.ok_s2 = h_reg.ok_s1;
		if (c_reg.cnt != EDGE_LAST) begin
			c_next.cnt = c_reg.cnt + 4'h1;
		end
		// A stray edge while deselected must not overwrite the reported mode.
		if (c_reg.cnt == 4'h0 && !cs_n_i) begin
			h_next.mode = frame_sync_i;
		end
		h_next.sh = cmd_now;
		if (c_reg.cnt == EDGE_CMD_DONE) begin
			h_next.cmd = cmd_now;
			c_next.cmd_lv = 1'b1;
			if (h_reg.ok_s2 && acs_is_conv(cmd_now)) begin
				c_next.samp_lv = 1'b1;
				c_next.samp_on = 1'b1;
			end
		end
		if (c_reg.cnt == EDGE_CONVERT && c_reg.samp_on) begin
			c_next.conv_lv = 1'b1;
		end
		// Output moves on the same edge that samples input.
		h_next.dout = (c_reg.cnt < 4'(RES_W)) ? shifted[RES_W-1] : 1'b0;
	end
	// Chip select high clears the cycle so each transfer counts from zero.
	always_ff @(posedge link_clk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			c_reg <= '0;
		end else begin
			c_reg <= c_next;
		end
	end
	// Held state survives chip select so the system side can read it.
	always_ff @(posedge link_clk_i) begin
		h_reg <= h_next;
	end
endmodule

// *** hdl/acs_sequencer.sv ***
// Top of the converter control sequencer on the system clock.
`timescale 1ns/1ps
module acs_sequencer (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic serial_clk_i,
	input wire logic cs_n_i,
	input wire logic frame_sync_i,
	input wire logic data_in_i,
	input wire logic sample_start_strobe_n_i,
	input wire logic clock_invert_n_i,
	input acs_pkg::acs_word_t adc_result_i,
	output logic data_out_o,
	output logic eoc_o,
	output logic sample_hold_o,
	output acs_pkg::acs_cmd_t channel_o,
	output logic fast_rate_o,
	output logic power_down_o,
	output logic readout_only_flag_o,
	output logic host_cpu_mode_o
);
	import acs_pkg::*;

	acs_seq_t r_reg, r_next;
	acs_link_t link;
	logic link_clk;
	logic edge_mode;
	logic cs_fall, cs_rise;
	logic sb_fall, sb_rise;
	logic ev_cmd, ev_samp, ev_conv;
	logic conv_done;
	logic ext_go;
	acs_word_t result;

	// Rising edge samples when the mode matches the invert pin.
	// The select is stable during a transfer, so the mux cannot glitch.
	assign link_clk = serial_clk_i ^ (edge_mode ^ clock_invert_n_i);

	// Serial side runs on the derived link clock.
	acs_link u_link (
		.link_clk_i(link_clk),
		.cs_n_i(cs_n_i),
		.frame_sync_i(frame_sync_i),
		.data_in_i(data_in_i),
		.conv_ok_i(r_reg.conv_ok),
		.out_word_i(r_reg.out_word),
		.link_o(link),
		.edge_mode_o(edge_mode),
		.host_cpu_mode_o(host_cpu_mode_o),
		.data_out_o(data_out_o)
	);

	// Edge and event detection after the synchronisers.
	assign cs_fall = r_reg.cs_d & ~r_reg.cs_s2;
	assign cs_rise = ~r_reg.cs_d & r_reg.cs_s2;
	assign sb_fall = r_reg.sb_d & ~r_reg.sb_s2;
	assign sb_rise = ~r_reg.sb_d & r_reg.sb_s2;
	// Link events arrive as levels, so only their rising edge counts.
	assign ev_cmd = r_reg.tg_s2[2] & ~r_reg.tg_d[2];
	assign ev_samp = r_reg.tg_s2[1] & ~r_reg.tg_d[1];
	assign ev_conv = r_reg.tg_s2[0] & ~r_reg.tg_d[0];
	assign conv_done = (r_reg.st == ST_CONVERT) && (r_reg.cnt == 10'h000);
	// Extended sampling needs chip select high and an awake device.
	assign ext_go = sb_fall & r_reg.cs_s2 & ~r_reg.pwr_dn;

	// Test codes give fixed results instead of the analogue value.
	always_comb begin
		unique case (r_reg.chan)
			CMD_TEST_MID: result = RES_MID;
			CMD_TEST_LO: result = RES_LO;
			CMD_TEST_HI: result = RES_HI;
			default: result = adc_result_i;
		endcase
	end

	// Next state of the whole sequencer.
	always_comb begin
		r_next = r_reg;
		// Pins and link toggles pass two flip-flops first.
		r_next.cs_s1 = cs_n_i;
		r_next.cs_s2 = r_reg.cs_s1;
		r_next.cs_d = r_reg.cs_s2;
		r_next.sb_s1 = sample_start_strobe_n_i;
		r_next.sb_s2 = r_reg.sb_s1;
		r_next.sb_d = r_reg.sb_s2;
		r_next.tg_s1 = {link.cmd_tgl, link.samp_tgl, link.conv_tgl};
		r_next.tg_s2 = r_reg.tg_s1;
		r_next.tg_d = r_reg.tg_s2;

		// The flag decides at chip-select fall whether this cycle converts.
		if (cs_fall) begin
			r_next.conv_ok = ~r_reg.flag;
			r_next.pwr_dn = 1'b0;
		end
		// Rise ends the cycle: flag takes the pending read-out state.
		if (cs_rise) begin
			r_next.flag = r_reg.pend;
			r_next.pend = 1'b0;
		end

		// A complete command applies at once in the same cycle.
		if (ev_cmd) begin
			if (link.cmd == CMD_PWRDN) begin
				r_next.pwr_dn = 1'b1;
			end else if (link.cmd == CMD_FAST) begin
				r_next.fast = 1'b1;
			end else if (link.cmd == CMD_SLOW) begin
				r_next.fast = 1'b0;
			end else if (acs_is_conv(link.cmd)) begin
				r_next.chan = link.cmd;
			end
		end

		unique case (r_reg.st)
			ST_IDLE: begin
				if (ext_go) begin
					r_next.st = ST_EXT_SAMPLE;
					r_next.sh = 1'b1;
					r_next.out_word = RES_LO;
					r_next.flag = 1'b1;
					r_next.pend = 1'b1;
				end else if (ev_samp) begin
					r_next.st = ST_NORM_SAMPLE;
					r_next.sh = 1'b1;
				end
			end
			ST_NORM_SAMPLE: begin
				// Six serial periods later the link asks for the hold.
				if (ev_conv) begin
					r_next.st = ST_CONVERT;
					r_next.sh = 1'b0;
					r_next.eoc = 1'b0;
					r_next.cnt = r_reg.fast ? CONV_FAST_CYC : CONV_SLOW_CYC;
				end
			end
			ST_EXT_SAMPLE: begin
				// Sampling lasts while the strobe stays low.
				if (sb_rise) begin
					r_next.st = ST_EXT_WAIT;
					r_next.sh = 1'b0;
					r_next.cnt = START_DELAY_CYC - 10'h001;
				end
			end
			ST_EXT_WAIT: begin
				if (r_reg.cnt == 10'h000) begin
					r_next.st = ST_CONVERT;
					r_next.eoc = 1'b0;
					r_next.cnt = r_reg.fast ? CONV_FAST_CYC : CONV_SLOW_CYC;
				end else begin
					r_next.cnt = r_reg.cnt - 10'h001;
				end
			end
			ST_CONVERT: begin
				if (conv_done) begin
					r_next.st = ST_IDLE;
					r_next.eoc = 1'b1;
					r_next.out_word = result;
				end else begin
					r_next.cnt = r_reg.cnt - 10'h001;
				end
			end
			default: begin
				r_next.st = ST_IDLE;
			end
		endcase

		// A new strobe restarts sampling even mid conversion.
		if (ext_go && r_reg.st != ST_IDLE) begin
			r_next.st = ST_EXT_SAMPLE;
			r_next.sh = 1'b1;
			r_next.eoc = 1'b1;
			r_next.out_word = RES_LO;
			r_next.flag = 1'b1;
			r_next.pend = 1'b1;
		end

		// Power-up leaves conversion idle with a cleared command.
		if (sys_rst_i) begin
			r_next = '0;
			r_next.st = ST_IDLE;
			r_next.eoc = EOC_RST;
			r_next.chan = CMD_RST;
			r_next.fast = FAST_RST;
			r_next.cs_s1 = 1'b1;
			r_next.cs_s2 = 1'b1;
			r_next.cs_d = 1'b1;
			r_next.sb_s1 = 1'b1;
			r_next.sb_s2 = 1'b1;
			r_next.sb_d = 1'b1;
		end
	end

	// One register bank holds the whole system-side state.
	always_ff @(posedge clk_i) begin
		r_reg <= r_next;
	end

	// Every output is a plain register bit.
	assign eoc_o = r_reg.eoc;
	assign sample_hold_o = r_reg.sh;
	assign channel_o = r_reg.chan;
	assign fast_rate_o = r_reg.fast;
	assign power_down_o = r_reg.pwr_dn;
	assign readout_only_flag_o = r_reg.flag;

	// Checks on the system clock.
	default clocking cb_sys @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Hold phase after the strobe rises, then two-cycle wait.
	sequence s_ext_wait;
		(r_reg.st == ST_EXT_WAIT) ##1 (r_reg.st == ST_EXT_WAIT);
	endsequence
	sequence s_conv_begin;
		(r_reg.st == ST_CONVERT) && !r_reg.eoc;
	endsequence

	a_ext_start: assert property (
		(ext_go && r_reg.st == ST_IDLE) |=> (r_reg.st == ST_EXT_SAMPLE) && r_reg.sh
	) else $error("extended sampling did not start");

	a_ext_hold_end: assert property (
		(r_reg.st == ST_EXT_SAMPLE && sb_rise && !ext_go) |=> !r_reg.sh
	) else $error("sample not held at strobe rise");

	a_result_discard: assert property (
		ext_go |=> (r_reg.out_word == RES_LO) && r_reg.flag
	) else $error("pending result not discarded");

	a_conv_delay: assert property (
		(r_reg.st == ST_EXT_SAMPLE && sb_rise && !ext_go)
		|=> s_ext_wait ##1 s_conv_begin
	) else $error("conversion not two clocks after strobe rise");

	a_flag_rise: assert property (
		cs_rise && !ext_go |=> r_reg.flag == $past(r_reg.pend)
	) else $error("flag wrong after chip-select rise");

	a_flag_test: assert property (
		cs_fall |=> r_reg.conv_ok == !$past(r_reg.flag)
	) else $error("flag not tested at chip-select fall");

	a_ext_cs_high: assert property (
		$rose(r_reg.st == ST_EXT_SAMPLE) |-> $past(r_reg.cs_s2)
	) else $error("extended sampling with chip select low");

	a_rate_fast: assert property (
		(ev_cmd && link.cmd == CMD_FAST) |=> r_reg.fast [*2]
	) else $error("fast rate not taken");

	a_rate_slow: assert property (
		(ev_cmd && link.cmd == CMD_SLOW) |=> !r_reg.fast
	) else $error("slow rate not taken");

	a_pd_rate: assert property (
		($changed(r_reg.pwr_dn) && !$past(ev_cmd)) |-> $stable(r_reg.fast)
	) else $error("power-down changed the rate");

	a_pd_enter: assert property (
		(ev_cmd && link.cmd == CMD_PWRDN) |=> r_reg.pwr_dn
	) else $error("power-down code ignored");

	a_pd_wake: assert property (
		(cs_fall && !ev_cmd) |=> !r_reg.pwr_dn
	) else $error("chip-select fall did not wake");

	a_eoc_busy: assert property (
		(r_reg.st == ST_CONVERT) |-> !r_reg.eoc ##0 !r_reg.sh
	) else $error("end-of-conversion high while converting");

	a_test_mid: assert property (
		(conv_done && r_reg.chan == CMD_TEST_MID && !ext_go)
		|=> r_reg.eoc && r_reg.out_word == RES_MID
	) else $error("mid test result wrong");

	a_test_hi: assert property (
		(conv_done && r_reg.chan == CMD_TEST_HI && !ext_go)
		|=> r_reg.out_word == RES_HI
	) else $error("high test result wrong");
endmodule

// *** tb/acs_host_model.sv ***
// Host serial port model: chip-select frames, result read-back and start strobe.
`timescale 1ns/1ps
module acs_host_model (
	output logic serial_clk_o,
	output logic cs_n_o,
	output logic frame_sync_o,
	output logic data_in_o,
	output logic sample_start_strobe_n_o,
	input wire logic data_out_i,
	input wire logic clock_invert_n_i
);
	import acs_pkg::*;
	// Idle: clock parked low, chip select, frame sync and strobe high.
	initial begin
		serial_clk_o = 1'b0;
		cs_n_o = 1'b1;
		frame_sync_o = 1'b1;
		data_in_o = 1'b0;
		sample_start_strobe_n_o = 1'b1;
	end
	// One 16-period frame at 80 ns; the clock only runs inside the frame.
	task automatic frame(input logic mode, input acs_cmd_t cmd, output acs_word_t res);
		logic rise;
		rise = (mode == clock_invert_n_i);
		// Frame sync settles first so its swap of edges cannot count as a bit.
		#12 frame_sync_o = mode;
		#1 cs_n_o = 1'b0;
		#100;
		for (int i = 0; i < 16; i++) begin
			#1 data_in_o = (i < CMD_W) ? cmd[CMD_W-1-i] : ~data_in_o;
			#38 if (!rise && i > 0 && i <= RES_W) res[RES_W-i] = data_out_i;
			#1 serial_clk_o = 1'b1;
			#39 if (rise && i < RES_W) res[RES_W-1-i] = data_out_i;
			#1 serial_clk_o = 1'b0;
		end
		#39 cs_n_o = 1'b1;
		frame_sync_o = 1'b1;
		data_in_o = ~data_in_o; // Released line shows no stale value.
		#200;
	endtask
	// Extended sampling; only ever pulsed while chip select is high.
	task automatic strobe(input int low_ns);
		sample_start_strobe_n_o = 1'b0;
		#(low_ns) sample_start_strobe_n_o = 1'b1;
	endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the converter control sequencer with a host model.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			$display("unexpected %s expected %h seen %h", nm, exp, got); \
			errors++; \
		end \
	end
module testbench;
	import acs_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clock_invert_n_i = 1'b1;
	acs_word_t adc_result_i = 10'h2A5;
	logic serial_clk, cs_n, frame_sync, data_in, strobe_n, data_out;
	logic eoc_o, hold_o, fast_o, pwr_o, flag_o, cpu_mode_o;
	acs_cmd_t channel_o;
	acs_word_t res;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int low_cnt = 0;
	int last_low = 0;
	localparam acs_cmd_t CODES [5] = '{CMD_TEST_MID, 4'h5, CMD_TEST_HI, CMD_TEST_LO, CMD_FAST};
	localparam acs_word_t PREV [5] = '{RES_LO, RES_MID, 10'h2A5, RES_HI, RES_LO};
	localparam logic [4:0] MODES = 5'b10011;
	localparam logic [4:0] INVS = 5'b10101;

	acs_host_model i_host (.serial_clk_o(serial_clk), .cs_n_o(cs_n),
		.frame_sync_o(frame_sync), .data_in_o(data_in), .sample_start_strobe_n_o(strobe_n),
		.data_out_i(data_out), .clock_invert_n_i(clock_invert_n_i));
	acs_sequencer i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .serial_clk_i(serial_clk),
		.cs_n_i(cs_n), .frame_sync_i(frame_sync), .data_in_i(data_in),
		.sample_start_strobe_n_i(strobe_n), .clock_invert_n_i(clock_invert_n_i),
		.adc_result_i(adc_result_i), .data_out_o(data_out), .eoc_o(eoc_o),
		.sample_hold_o(hold_o), .channel_o(channel_o), .fast_rate_o(fast_o),
		.power_down_o(pwr_o), .readout_only_flag_o(flag_o), .host_cpu_mode_o(cpu_mode_o));

	always #12.5 clk_i = ~clk_i;

	// Cycle ceiling, and the width of each end-of-conversion low pulse.
	always @(posedge clk_i) begin
		cycles++;
		low_cnt <= eoc_o ? 0 : low_cnt + 1;
		if (eoc_o && low_cnt != 0) last_low <= low_cnt;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Bounded wait; settles one step past the edge to avoid update races.
	task automatic wait_eoc(input logic v);
		for (int i = 0; i < 1000 && eoc_o !== v; i++) begin
			@(posedge clk_i);
			#1;
		end
		`CHK("eoc wait", v, eoc_o)
	endtask

	// One conversion; a wrong rate shows up as a wrong pulse width.
	task automatic conv(input logic fast);
		int n;
		n = fast ? int'(CONV_FAST_CYC) : int'(CONV_SLOW_CYC);
		wait_eoc(1'b0);
		wait_eoc(1'b1);
		@(posedge clk_i);
		#1;
		`CHK("conversion length", 1'b1, (last_low >= n && last_low <= n + 1))
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		`CHK("eoc", EOC_RST, eoc_o)
		`CHK("channel", CMD_RST, channel_o)
		`CHK("rate", FAST_RST, fast_o)
		`CHK("flag", 1'b0, flag_o)
		`CHK("power", 1'b0, pwr_o)
		`CHK("hold", 1'b0, hold_o)
		repeat (3) @(posedge clk_i);
		// All mode and clock-invert pairings; each frame reads the previous result.
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i);
			clock_invert_n_i <= INVS[i];
			@(posedge clk_i);
			i_host.frame(MODES[i], CODES[i], res);
			if (i > 0) `CHK("result", PREV[i], res)
			`CHK("mode", MODES[i], cpu_mode_o)
			if (i < 4) `CHK("channel", CODES[i], channel_o)
			if (i < 4) conv(1'b1);
		end
		`CHK("rate", 1'b1, fast_o)
		// The slow rate survives a power-down and its wake-up.
		i_host.frame(1'b1, CMD_SLOW, res);
		`CHK("rate", 1'b0, fast_o)
		i_host.frame(1'b1, CMD_PWRDN, res);
		`CHK("power", 1'b1, pwr_o)
		i_host.frame(1'b1, CMD_TEST_MID, res);
		`CHK("power", 1'b0, pwr_o)
		`CHK("rate", 1'b0, fast_o)
		conv(1'b0);
		i_host.frame(1'b1, CMD_FAST, res);
		// Extended sampling of the preset code, then two read-out cycles.
		i_host.frame(1'b1, CMD_TEST_HI, res);
		conv(1'b1);
		fork
			i_host.strobe(1000);
			begin
				#500;
				`CHK("hold", 1'b1, hold_o)
				`CHK("flag", 1'b1, flag_o)
			end
		join
		repeat (3) @(posedge clk_i);
		#1;
		`CHK("eoc", 1'b1, eoc_o)
		repeat (5) @(posedge clk_i);
		#1;
		`CHK("hold", 1'b0, hold_o)
		`CHK("eoc", 1'b0, eoc_o)
		conv(1'b1);
		i_host.frame(1'b1, CMD_TEST_MID, res);
		`CHK("result", RES_HI, res)
		`CHK("flag", 1'b1, flag_o)
		`CHK("eoc", 1'b1, eoc_o)
		i_host.frame(1'b1, CMD_TEST_MID, res);
		`CHK("flag", 1'b0, flag_o)
		`CHK("eoc", 1'b1, eoc_o)
		i_host.frame(1'b1, CMD_TEST_MID, res);
		conv(1'b1);
		i_host.frame(1'b1, CMD_FAST, res);
		`CHK("result", RES_MID, res)
		end_of_test();
	end
endmodule
